/* design/mocrt_map.vh */
`ifndef MOCRT_MAP_VH
`define MOCRT_MAP_VH

// Frame framing overhead: destination, source, length/type and FCS.
`define MOCRT_HDR_FCS_BYTES 16'h0012
// Smallest legal frame in bytes.
`define MOCRT_MIN_FRAME 16'h0040
// Default largest legal frame in bytes.
`define MOCRT_MAX_FRAME 16'h05EE
// Default fixed egress latency added to the exit stamp, in time units.
`define MOCRT_EXIT_LATENCY 96'h0
// Reset value of every count and of the wide and narrow stamps.
`define MOCRT_ZERO_COUNT 16'h0000
`define MOCRT_ZERO_WIDE 96'h0
`define MOCRT_ZERO_NARROW 64'h0

`endif

/* design/mocrt_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "mocrt_map.vh"

// Per-frame payload byte counter for one direction.
module mocrt_octcnt #(
  parameter BW = 7,
  parameter [15:0] MAX_FRAME = `MOCRT_MAX_FRAME
) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Frame beats
  input wire sop,
  input wire beat,
  input wire [BW-1:0] nbytes,
  input wire eop,
  input wire fcs_err,
  input wire len_err,
  // Per-frame result
  output reg [15:0] count,
  output reg count_valid
);
  localparam ST_IDLE = 1'b0;
  localparam ST_FRAME = 1'b1;

  reg state;
  reg next_state;
  reg [15:0] acc;
  reg [15:0] next_acc;
  reg [16:0] sum;
  reg [15:0] total;
  reg take;
  reg close;
  reg qualify;

  // Beat accounting and frame qualification.
  always @* begin
    // A beat counts only when it opens a frame or falls inside one.
    take = beat && (sop || state == ST_FRAME);
    close = take && eop;
    sum = {1'b0, (sop ? `MOCRT_ZERO_COUNT : acc)} + {{(17-BW){1'b0}}, nbytes};
    // Saturate so a runaway frame stays oversized instead of wrapping.
    total = sum[16] ? 16'hFFFF : sum[15:0];
    qualify = !fcs_err && !len_err && (total >= `MOCRT_MIN_FRAME) && (total <= MAX_FRAME);
    next_acc = take ? total : acc;
  end

  // Frame tracking.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && !eop) begin
          next_state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (close) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      acc <= `MOCRT_ZERO_COUNT;
      count <= `MOCRT_ZERO_COUNT;
      count_valid <= 1'b0;
    end else begin
      state <= next_state;
      acc <= next_acc;
      count_valid <= close && qualify;
      if (close && qualify) begin
        count <= total - `MOCRT_HDR_FCS_BYTES;
      end
    end
  end
endmodule

// Capture stage for one arrival stamp format.
module mocrt_stamp_hold #(
  parameter W = 96,
  parameter EN = 1
) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Capture strobe and running time
  input wire capture,
  input wire [W-1:0] time_in,
  // Time captured at the last arrival
  output reg [W-1:0] held
);
  reg [W-1:0] next_held;

  always @* begin
    next_held = held;
    // A disabled format keeps a zero stamp so no stale time leaks out.
    if (capture && EN != 0) begin
      next_held = time_in;
    end
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      held <= {W{1'b0}};
    end else begin
      held <= next_held;
    end
  end
endmodule

// Notes on behaviour
// - Receive counts produced on mclk.
// - Transmit counts produced on mclk.
// - Sixteen-bit payload count per direction.
// - Transmit valid pulses only for qualifying frames.
// - Receive valid pulses only for qualifying frames.
// - Qualifying: no FCS, size or length error.
// - With timing enabled, stamp every received packet.
// - Stamp presented two cycles after link arrival.
// - Stamp sampled at link arrival, then held.
// - Fingerprint passes through unmodified.
// - With timing and the wide format enabled, outgoing timing packets get two-step exit stamps.
// - Hardware stamping only, no protocol layers.
// - Counts work without statistics counters.
module mocrt_top #(
  parameter BW = 7,
  parameter FPW = 8,
  parameter PTP_EN = 1,
  parameter WIDE_EN = 1,
  parameter NARROW_EN = 1,
  parameter [15:0] MAX_FRAME = `MOCRT_MAX_FRAME,
  parameter [95:0] EXIT_LATENCY = `MOCRT_EXIT_LATENCY
) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Transmit frame beats
  input wire tx_sop,
  input wire tx_beat,
  input wire [BW-1:0] tx_nbytes,
  input wire tx_eop,
  input wire tx_fcs_err,
  input wire tx_len_err,
  // Transmit per-frame count
  output wire [15:0] tx_octet_count,
  output wire tx_octet_valid,
  // Receive frame beats
  input wire rx_sop,
  input wire rx_beat,
  input wire [BW-1:0] rx_nbytes,
  input wire rx_eop,
  input wire rx_fcs_err,
  input wire rx_len_err,
  // Receive per-frame count
  output wire [15:0] rx_octet_count,
  output wire rx_octet_valid,
  // Time inputs from the wall_time_source
  input wire [95:0] rx_clock_time_wide_in,
  input wire [63:0] rx_clock_time_narrow_in,
  input wire [95:0] tx_clock_time_wide_in,
  // Receive arrival stamp
  input wire rx_link_arrival,
  output reg [95:0] rx_arrival_stamp_wide,
  output reg [63:0] rx_arrival_stamp_narrow,
  // Transmit two-step stamp request
  input wire tx_stamp_req,
  input wire [FPW-1:0] tx_stamp_fp_in,
  output reg [95:0] tx_exit_stamp_wide,
  output reg [FPW-1:0] tx_exit_stamp_fp,
  output reg tx_exit_stamp_valid
);
  reg [95:0] pend_wide;
  reg [FPW-1:0] pend_fp;
  reg pend;
  reg next_pend;
  reg [95:0] next_pend_wide;
  reg [FPW-1:0] next_pend_fp;
  reg next_exit_valid;
  reg [95:0] next_exit_wide;
  reg [FPW-1:0] next_exit_fp;
  wire [95:0] held_wide;
  wire [63:0] held_narrow;
  // One arrival stamp is shown two cycles after its arrival; a new arrival replaces it.
  wire rx_capture = rx_link_arrival && (PTP_EN != 0);
  wire exit_req = tx_stamp_req && tx_sop && tx_beat && (PTP_EN != 0) && (WIDE_EN != 0);
  wire [95:0] exit_time = tx_clock_time_wide_in + EXIT_LATENCY;

  mocrt_octcnt #(.BW(BW), .MAX_FRAME(MAX_FRAME)) u_tx_cnt (
    .mclk(mclk),
    .nrst(nrst),
    .sop(tx_sop),
    .beat(tx_beat),
    .nbytes(tx_nbytes),
    .eop(tx_eop),
    .fcs_err(tx_fcs_err),
    .len_err(tx_len_err),
    .count(tx_octet_count),
    .count_valid(tx_octet_valid)
  );

  mocrt_octcnt #(.BW(BW), .MAX_FRAME(MAX_FRAME)) u_rx_cnt (
    .mclk(mclk),
    .nrst(nrst),
    .sop(rx_sop),
    .beat(rx_beat),
    .nbytes(rx_nbytes),
    .eop(rx_eop),
    .fcs_err(rx_fcs_err),
    .len_err(rx_len_err),
    .count(rx_octet_count),
    .count_valid(rx_octet_valid)
  );

  mocrt_stamp_hold #(.W(96), .EN(WIDE_EN)) u_rx_wide (
    .mclk(mclk),
    .nrst(nrst),
    .capture(rx_capture),
    .time_in(rx_clock_time_wide_in),
    .held(held_wide)
  );

  mocrt_stamp_hold #(.W(64), .EN(NARROW_EN)) u_rx_narrow (
    .mclk(mclk),
    .nrst(nrst),
    .capture(rx_capture),
    .time_in(rx_clock_time_narrow_in),
    .held(held_narrow)
  );

  always @(posedge mclk) begin
    if (!nrst) begin
      rx_arrival_stamp_wide <= `MOCRT_ZERO_WIDE;
      rx_arrival_stamp_narrow <= `MOCRT_ZERO_NARROW;
    end else begin
      rx_arrival_stamp_wide <= held_wide;
      rx_arrival_stamp_narrow <= held_narrow;
    end
  end

  // Two-step stamps: one frame at a time waits between its request and its end.
  always @* begin
    next_pend = pend;
    next_pend_wide = pend_wide;
    next_pend_fp = pend_fp;
    next_exit_valid = 1'b0;
    next_exit_wide = tx_exit_stamp_wide;
    next_exit_fp = tx_exit_stamp_fp;
    if (exit_req) begin
      if (tx_eop) begin
        // A single-beat frame is already complete, so its stamp leaves at once.
        next_pend = 1'b0;
        next_exit_valid = 1'b1;
        next_exit_wide = exit_time;
        next_exit_fp = tx_stamp_fp_in;
      end else begin
        next_pend = 1'b1;
        next_pend_wide = exit_time;
        next_pend_fp = tx_stamp_fp_in;
      end
    end else if (pend && tx_beat && tx_eop) begin
      next_pend = 1'b0;
      next_exit_valid = 1'b1;
      next_exit_wide = pend_wide;
      next_exit_fp = pend_fp;
    end
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      pend <= 1'b0;
      pend_wide <= `MOCRT_ZERO_WIDE;
      pend_fp <= {FPW{1'b0}};
      tx_exit_stamp_wide <= `MOCRT_ZERO_WIDE;
      tx_exit_stamp_fp <= {FPW{1'b0}};
      tx_exit_stamp_valid <= 1'b0;
    end else begin
      pend <= next_pend;
      pend_wide <= next_pend_wide;
      pend_fp <= next_pend_fp;
      tx_exit_stamp_valid <= next_exit_valid;
      tx_exit_stamp_wide <= next_exit_wide;
      tx_exit_stamp_fp <= next_exit_fp;
    end
  end
endmodule

`default_nettype wire

/* dv/mocrt_tod.sv */
`timescale 1ns/1ps
`default_nettype none
module mocrt_tod (
  // Clock and time
  input wire logic mclk,
  output logic [95:0] wide,
  output logic [63:0] narrow,
  output logic [95:0] tx_wide
);
  logic [63:0] t = 64'h0;
  always @(posedge mclk) t <= t + 64'h1_0000_0007;
  assign wide = {t[31:0], t};
  assign narrow = t;
  assign tx_wide = {t, t[63:32]};
endmodule
`default_nettype wire

/* dv/mocrt_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module mocrt_top_asserts (
  // Watched ports
  input wire logic mclk,
  input wire logic nrst,
  input wire logic tx_eop,
  input wire logic [15:0] tx_octet_count,
  input wire logic tx_octet_valid,
  input wire logic rx_eop,
  input wire logic [15:0] rx_octet_count,
  input wire logic rx_octet_valid,
  input wire logic [95:0] rx_clock_time_wide_in,
  input wire logic rx_link_arrival,
  input wire logic [95:0] rx_arrival_stamp_wide,
  input wire logic tx_exit_stamp_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_tx_pulse: assert property (tx_octet_valid |=> !tx_octet_valid) else $error("tx");
  a_rx_pulse: assert property (rx_octet_valid |=> !rx_octet_valid) else $error("rx");
  a_tx_cause: assert property (tx_octet_valid |-> $past(tx_eop)) else $error("tx");
  a_rx_cause: assert property (rx_octet_valid |-> $past(rx_eop)) else $error("rx");
  a_tx_keep: assert property (!tx_octet_valid |-> $stable(tx_octet_count)) else $error("tx");
  a_rx_keep: assert property (!rx_octet_valid |-> $stable(rx_octet_count)) else $error("rx");
  a_stamp_sample: assert property (rx_link_arrival |-> ##2
    rx_arrival_stamp_wide == $past(rx_clock_time_wide_in, 2)) else $error("stamp");
  a_exit_pulse: assert property (tx_exit_stamp_valid |-> $past(tx_eop) ##1
    !tx_exit_stamp_valid) else $error("exit");
  cover property (tx_octet_valid);
  cover property (rx_octet_valid);
  cover property (tx_exit_stamp_valid);
endmodule
bind mocrt_top mocrt_top_asserts i_mocrt_top_asserts (.*);
`default_nettype wire

/* dv/mocrt_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module mocrt_top_bench;
  logic mclk = 0, nrst = 0, sop = 0, bt = 0, eop = 0, fe = 0, le = 0, arr = 0, rq = 0;
  logic tv, rv, xv;
  logic [6:0] nb = 7'h00;
  logic [7:0] fp = 8'h00, xf, lxf;
  logic [15:0] tc, rc, ltc;
  logic [63:0] tn, sn;
  logic [95:0] tw, tt, sw, ew, lew, et;
  int n_fail = 0, tests_run = 0, cyc = 0, ntv, nrv, nxv;
  mocrt_tod i_mocrt_tod (.mclk(mclk), .wide(tw), .narrow(tn), .tx_wide(tt));
  mocrt_top i_mocrt_top (.mclk(mclk), .nrst(nrst), .tx_sop(sop), .tx_beat(bt),
    .tx_nbytes(nb), .tx_eop(eop), .tx_fcs_err(fe), .tx_len_err(le), .tx_octet_count(tc),
    .tx_octet_valid(tv), .rx_sop(sop), .rx_beat(bt), .rx_nbytes(nb), .rx_eop(eop),
    .rx_fcs_err(fe), .rx_len_err(le), .rx_octet_count(rc), .rx_octet_valid(rv),
    .rx_clock_time_wide_in(tw), .rx_clock_time_narrow_in(tn), .tx_clock_time_wide_in(tt),
    .rx_link_arrival(arr), .rx_arrival_stamp_wide(sw), .rx_arrival_stamp_narrow(sn),
    .tx_stamp_req(rq), .tx_stamp_fp_in(fp), .tx_exit_stamp_wide(ew), .tx_exit_stamp_fp(xf),
    .tx_exit_stamp_valid(xv));
  initial forever #25 mclk = ~mclk;
  always @(negedge mclk) begin
    ntv += (tv === 1'b1);
    nrv += (rv === 1'b1);
    if (tv === 1'b1) ltc = tc;
    if (xv === 1'b1) begin
      nxv++;
      lew = ew;
      lxf = xf;
    end
  end
  always @(posedge mclk) if (++cyc == 3000) begin
    n_fail++;
    final_report;
  end
  // Sends one frame on both directions, then checks pulse counts and held counts.
  task automatic run(input int n, input logic f, l, q, input int ok);
    int r;
    logic [15:0] e;
    r = n;
    e = ok ? 16'(n - 18) : tc;
    {ntv, nrv, nxv} = 0;
    while (r > 0) begin
      @(negedge mclk);
      sop = (r == n);
      rq = q && sop;
      if (sop) et = tt;
      bt = 1;
      nb = (r > 127) ? 7'h7F : 7'(r);
      r = r - nb;
      {eop, fe, le} = {r == 0, f, l};
    end
    @(negedge mclk);
    {sop, rq, bt, eop, fe, le} = 6'h00;
    @(negedge mclk);
    `CHK(ntv, ok)
    `CHK(nrv, ok)
    `CHK(tc, e)
    `CHK(rc, e)
    `CHK(ltc, e)
  endtask
  task automatic t_sizes;
    run(100, 0, 0, 0, 1);
    run(64, 0, 0, 0, 1);
    run(1518, 0, 0, 0, 1);
  endtask
  task automatic t_errors;
    run(100, 1, 0, 0, 0);
    run(100, 0, 1, 0, 0);
    run(63, 0, 0, 0, 0);
    run(1519, 0, 0, 0, 0);
  endtask
  task automatic t_stamp;
    logic [95:0] w;
    logic [63:0] m;
    @(negedge mclk);
    {arr, w, m} = {1'b1, tw, tn};
    @(negedge mclk);
    arr = 0;
    @(negedge mclk);
    run(90, 0, 0, 0, 1);
    `CHK(sw, w)
    `CHK(sn, m)
  endtask
  task automatic t_exit;
    fp = 8'hA5;
    run(80, 0, 0, 1, 1);
    `CHK(nxv, 1)
    `CHK(lew, et)
    `CHK(lxf, 8'hA5)
    fp = 8'h3C;
    run(200, 0, 0, 1, 1);
    `CHK(nxv, 1)
    `CHK(lew, et)
    `CHK(lxf, 8'h3C)
  endtask
  task automatic final_report;
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    nrst = 1;
    t_sizes;
    t_errors;
    t_stamp;
    t_exit;
    final_report;
  end
endmodule
`default_nettype wire
